/* core/cmplos_defs.vh */
// Constants for the comparator, soft limit and out-of-step block.
`ifndef CMPLOS_DEFS_VH
`define CMPLOS_DEFS_VH
// Register byte offsets on APB.
`define CMPLOS_OFS_ENC_CFG 12'h000
`define CMPLOS_OFS_CMP_CFG_A 12'h004
`define CMPLOS_OFS_CMP_CFG_B 12'h008
`define CMPLOS_OFS_DEV_CNT 12'h00c
`define CMPLOS_OFS_CMP_VAL0 12'h010
`define CMPLOS_OFS_ERR_CAUSE 12'h024
`define CMPLOS_OFS_MAIN_STATE 12'h028
`define CMPLOS_OFS_COMMAND 12'h02c
`define CMPLOS_OFS_ERR_MASK 12'h030
// Command codes.
`define CMPLOS_CMD_DEV_CLR 8'h22
// Field positions.
`define CMPLOS_EIM_LO 20
`define CMPLOS_ENCODER_COUNT_DIRECTION_BIT 22
`define CMPLOS_ENCODER_INPUT_FAULT_BIT 16
`define CMPLOS_SCP_LO 8
// Target selects.
`define CMPLOS_TGT_C1 2'b00
`define CMPLOS_TGT_C2 2'b01
`define CMPLOS_TGT_DEV 2'b10
`define CMPLOS_TGT_C4 2'b11
`define CMPLOS_TGT5_DEV 3'b010
// Conditions.
`define CMPLOS_CND_EQ 3'b001
`define CMPLOS_CND_EQ_UP 3'b010
`define CMPLOS_CND_EQ_DN 3'b011
`define CMPLOS_CND_GT 3'b100
`define CMPLOS_CND_LT 3'b101
`define CMPLOS_CND_SL 3'b110
// Actions.
`define CMPLOS_ACT_NONE 2'b00
`define CMPLOS_ACT_STOP 2'b01
`define CMPLOS_ACT_DECEL 2'b10
`define CMPLOS_ACT_BULK 2'b11
// Encoder formats.
`define CMPLOS_EIM_X1 2'b00
`define CMPLOS_EIM_X2 2'b01
`define CMPLOS_EIM_X4 2'b10
`define CMPLOS_EIM_2P 2'b11
`endif

/* core/cmplos_encoder.v */
// Encoder decoder producing count pulses and input errors.
`default_nettype none
`include "cmplos_defs.vh"
module cmplos_encoder (
	input wire clk,
	input wire srst,
	input wire encoder_phase_a,
	input wire encoder_phase_b,
	input wire [1:0] encoder_input_format,
	input wire encoder_count_direction,
	output reg cnt_up,
	output reg cnt_dn,
	output reg input_err
);
	// =====================================================================
	// Edge detection.
	reg a_d;
	reg b_d;
	wire ea = encoder_phase_a ^ a_d;
	wire eb = encoder_phase_b ^ b_d;
	// Phase A leading B gives forward; the direction bit chooses the sign.
	wire fwd_a = encoder_phase_a ^ encoder_phase_b;
	wire fwd_b = ~(encoder_phase_a ^ encoder_phase_b);
	reg step;
	reg fwd;
	always @* begin
		step = 1'b0;
		fwd = 1'b0;
		case (encoder_input_format)
			`CMPLOS_EIM_X1: begin
				step = ea & encoder_phase_a & ~eb;
				fwd = ~encoder_phase_b;
			end
			`CMPLOS_EIM_X2: begin
				step = ea & ~eb;
				fwd = fwd_a;
			end
			`CMPLOS_EIM_X4: begin
				step = ea ^ eb;
				fwd = ea ? fwd_a : fwd_b;
			end
			default: begin
				// Two-pulse mode: rising edge of A is forward, of B reverse.
				step = (ea & encoder_phase_a) ^ (eb & encoder_phase_b);
				fwd = ea & encoder_phase_a;
			end
		endcase
	end
	// Registered outputs so the counter sees clean one-cycle pulses.
	always @(posedge clk) begin
		if (srst) begin
			a_d <= 1'b0;
			b_d <= 1'b0;
			cnt_up <= 1'b0;
			cnt_dn <= 1'b0;
			input_err <= 1'b0;
		end else begin
			a_d <= encoder_phase_a;
			b_d <= encoder_phase_b;
			cnt_up <= step & (fwd ~^ encoder_count_direction); // [R16]
			cnt_dn <= step & (fwd ^ encoder_count_direction); // [R16]
			if (encoder_input_format == `CMPLOS_EIM_2P) begin
				input_err <= ea & encoder_phase_a & eb & encoder_phase_b; // [R14]
			end else begin
				input_err <= ea & eb; // [R14]
			end
		end
	end
endmodule
`default_nettype wire

/* core/cmplos_top.v */
// Five comparators with soft limits and stepper out-of-step detection.
// Functional notes
// R01: Comparators 1-4 target 00 counter1, 01 counter2, 11 counter4.
// R02: Target 10 compares against absolute deviation, 0 to 32767.
// R03: Comparator 5 target code 010 selects the deviation counter.
// R04: Comparator 1 condition 110 is positive limit: value below target.
// R05: Comparator 2 condition 110 is negative limit: value above target.
// R06: A met soft limit stops immediately even with action 00 or 11.
// R07: Actions: 00 none, 01 immediate, 10 decelerate, 11 bulk override.
// R08: Action fields at 6:5, 14:13, 22:21, 31:30 and 7:6 of config b.
// R09: Condition 101 (0101 on comparator 4) means value below target.
// R10: Error cause bits 0-4 record abnormal stops by comparators 1-5.
// R11: Deviation beyond tolerance with immediate stop halts and raises error.
// R12: Main state bits 8-12 show each comparator's met condition live.
// R13: Encoder input error sets error bit 16 without stopping.
// R14: Error on simultaneous phase change or simultaneous two-pulse inputs.
// R15: Encoder format bits 21:20: x1, x2, x4 quadrature, or two-pulse.
// R16: Direction bit 22 set counts up when phase A leads.
// R17: Deviation counter is signed 16-bit commands minus feedback, readable.
// R18: Command 22h clears the deviation counter to zero.
// R19: Each comparator has a 28-bit comparison value register.
// R20: Positive limit stops only moving positive; negative only moving negative.
// R21: A met limit refuses starts in that direction.
// R22: Error bits stay until software clears; interrupt follows enabled bits.
// R23: Comparators are evaluated every clock cycle.
`default_nettype none
`include "cmplos_defs.vh"
module cmplos_top #(
	parameter CW = 28,
	parameter DW = 16
) (
	input wire clk,
	input wire srst,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire [CW-1:0] position_counter_one,
	input wire [CW-1:0] position_counter_two,
	input wire [CW-1:0] general_counter_four,
	input wire [CW-1:0] speed_step,
	input wire cmd_pulse_up,
	input wire cmd_pulse_dn,
	input wire moving_pos,
	input wire moving_neg,
	input wire start_pos_req,
	input wire start_neg_req,
	input wire encoder_phase_a,
	input wire encoder_phase_b,
	output reg stop_immediate,
	output reg stop_decel,
	output reg bulk_override,
	output wire start_pos_ok,
	output wire start_neg_ok,
	output wire [4:0] compare_out,
	output wire err_irq
);
	// =====================================================================
	// Register file.
	reg [31:0] encoder_io_config_reg;
	reg [31:0] comparator_config_a_reg;
	reg [31:0] comparator_config_b_reg;
	reg [31:0] err_mask_reg;
	reg [CW-1:0] cmp_val_reg [0:4]; // [R19]
	reg [DW-1:0] deviation_counter_reg;
	reg [DW-1:0] deviation_counter_next;
	reg [4:0] abort_flag_reg;
	reg [4:0] abort_flag_next;
	reg encoder_input_fault_reg;
	reg [4:0] met_reg;
	wire enc_up;
	wire enc_dn;
	wire enc_err;
	wire wr_en = psel & penable & pwrite;
	wire rd_en = psel & ~pwrite;
	wire [11:0] ofs_err_mask = `CMPLOS_OFS_ERR_MASK;
	// Each process owns its loop index so no variable has two drivers.
	integer k;
	integer j;
	integer i;
	// The slave answers in the first access cycle; all unmapped reads give zero.
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	// =====================================================================
	// Encoder front end.
	cmplos_encoder u_enc (
		.clk(clk),
		.srst(srst),
		.encoder_phase_a(encoder_phase_a),
		.encoder_phase_b(encoder_phase_b),
		.encoder_input_format(encoder_io_config_reg[`CMPLOS_EIM_LO+1:`CMPLOS_EIM_LO]), // [R15]
		.encoder_count_direction(encoder_io_config_reg[`CMPLOS_ENCODER_COUNT_DIRECTION_BIT]), // [R16]
		.cnt_up(enc_up),
		.cnt_dn(enc_dn),
		.input_err(enc_err)
	);
	// =====================================================================
	// Deviation: command pulses count up, feedback counts down. Wraps at 16 bits.
	always @* begin
		deviation_counter_next = deviation_counter_reg;
		case ({cmd_pulse_up, cmd_pulse_dn, enc_up, enc_dn})
			4'b1000, 4'b0001: deviation_counter_next = deviation_counter_reg + 16'h0001; // [R17]
			4'b0100, 4'b0010: deviation_counter_next = deviation_counter_reg - 16'h0001; // [R17]
			4'b1001: deviation_counter_next = deviation_counter_reg + 16'h0002;
			4'b0110: deviation_counter_next = deviation_counter_reg - 16'h0002;
			default: deviation_counter_next = deviation_counter_reg;
		endcase
		if (wr_en && paddr == `CMPLOS_OFS_COMMAND && pwdata[7:0] == `CMPLOS_CMD_DEV_CLR) begin
			deviation_counter_next = {DW{1'b0}}; // [R18]
		end else if (wr_en && paddr == `CMPLOS_OFS_DEV_CNT) begin
			deviation_counter_next = pwdata[DW-1:0];
		end
	end
	// Absolute deviation, saturated so -32768 gives 32767 rather than 32768.
	wire dev_neg = deviation_counter_reg[DW-1];
	wire [DW-1:0] dev_abs_raw = dev_neg ? (~deviation_counter_reg + 16'h0001) : deviation_counter_reg;
	wire [DW-1:0] dev_abs = dev_abs_raw[DW-1] ? {1'b0, {(DW-1){1'b1}}} : dev_abs_raw; // [R02]
	wire signed [CW-1:0] dev_abs_w = {{(CW-DW){1'b0}}, dev_abs};
	// Counting direction of the deviation, used by equal-when-up/down conditions.
	wire dir_up = cmd_pulse_up | enc_dn;
	wire dir_dn = cmd_pulse_dn | enc_up;
	// =====================================================================
	// Comparators, one generate instance each.
	wire [4:0] met_w;
	wire [4:0] is_sl;
	wire [9:0] act_w;
	assign act_w[1:0] = comparator_config_a_reg[6:5]; // [R08]
	assign act_w[3:2] = comparator_config_a_reg[14:13]; // [R08]
	assign act_w[5:4] = comparator_config_a_reg[22:21]; // [R08]
	assign act_w[7:6] = comparator_config_a_reg[31:30]; // [R08]
	assign act_w[9:8] = comparator_config_b_reg[7:6]; // [R08]
	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_cmp
			reg signed [CW-1:0] tgt;
			reg [2:0] cnd;
			reg m;
			wire signed [CW-1:0] val = cmp_val_reg[g];
			always @* begin
				tgt = position_counter_one;
				cnd = 3'b000;
				if (g < 4) begin
					case (comparator_config_a_reg[g*8+1 -: 2])
						`CMPLOS_TGT_C1: tgt = position_counter_one; // [R01]
						`CMPLOS_TGT_C2: tgt = position_counter_two; // [R01]
						`CMPLOS_TGT_DEV: tgt = dev_abs_w; // [R02]
						default: tgt = general_counter_four; // [R01]
					endcase
				end else begin
					case (comparator_config_b_reg[2:0])
						3'b000: tgt = position_counter_one;
						3'b001: tgt = position_counter_two;
						`CMPLOS_TGT5_DEV: tgt = dev_abs_w; // [R03]
						3'b011: tgt = general_counter_four;
						default: tgt = speed_step;
					endcase
				end
				if (g == 3) begin
					// Comparator 4 has a 4-bit code; only 0xxx codes map here.
					cnd = comparator_config_a_reg[29] ? 3'b000 : comparator_config_a_reg[28:26]; // [R09]
				end else if (g == 4) begin
					cnd = comparator_config_b_reg[5:3];
				end else begin
					cnd = comparator_config_a_reg[g*8+4 -: 3];
				end
				case (cnd)
					`CMPLOS_CND_EQ: m = (val == tgt);
					`CMPLOS_CND_EQ_UP: m = (val == tgt) & dir_up;
					`CMPLOS_CND_EQ_DN: m = (val == tgt) & dir_dn;
					`CMPLOS_CND_GT: m = (val > tgt);
					`CMPLOS_CND_LT: m = (val < tgt); // [R09]
					`CMPLOS_CND_SL: begin
						if (g == 0) begin
							m = (val < tgt); // [R04]
						end else if (g == 1) begin
							m = (val > tgt); // [R05]
						end else begin
							m = 1'b0;
						end
					end
					default: m = 1'b0;
				endcase
			end
			assign met_w[g] = m;
			assign is_sl[g] = (g < 2) && (cnd == `CMPLOS_CND_SL);
		end
	endgenerate
	// =====================================================================
	// Stop decision. Soft limits only act in their own direction.
	reg [4:0] fire_imm;
	reg [4:0] fire_dec;
	reg [4:0] fire_bulk;
	always @* begin
		for (k = 0; k < 5; k = k + 1) begin
			fire_imm[k] = 1'b0;
			fire_dec[k] = 1'b0;
			fire_bulk[k] = 1'b0;
			if (is_sl[k]) begin
				if (met_w[k] && ((k == 0 && moving_pos) || (k == 1 && moving_neg))) begin // [R20]
					fire_dec[k] = (act_w[k*2 +: 2] == `CMPLOS_ACT_DECEL);
					fire_imm[k] = ~fire_dec[k]; // [R06]
				end
			end else if (met_w[k]) begin
				fire_imm[k] = (act_w[k*2 +: 2] == `CMPLOS_ACT_STOP); // [R07] [R11]
				fire_dec[k] = (act_w[k*2 +: 2] == `CMPLOS_ACT_DECEL); // [R07]
				fire_bulk[k] = (act_w[k*2 +: 2] == `CMPLOS_ACT_BULK); // [R07]
			end
		end
		// Set wins over a software clear in the same cycle.
		abort_flag_next = abort_flag_reg;
		if (wr_en && paddr == `CMPLOS_OFS_ERR_CAUSE) begin
			abort_flag_next = abort_flag_reg & ~pwdata[4:0]; // [R22]
		end
		abort_flag_next = abort_flag_next | ((fire_imm | fire_dec) & {5{moving_pos | moving_neg}}); // [R10]
	end
	// Limits block starts only toward the limit.
	assign start_pos_ok = start_pos_req & ~(is_sl[0] & met_w[0]); // [R21]
	assign start_neg_ok = start_neg_req & ~(is_sl[1] & met_w[1]); // [R21]
	assign compare_out = met_reg;
	// The interrupt holds as long as any enabled cause is still set.
	assign err_irq = |({encoder_input_fault_reg, abort_flag_reg} & {err_mask_reg[16], err_mask_reg[4:0]}); // [R22] [R11]
	// =====================================================================
	// Sequential state and register writes.
	always @(posedge clk) begin
		if (srst) begin
			encoder_io_config_reg <= 32'h00000000;
			comparator_config_a_reg <= 32'h00000000;
			comparator_config_b_reg <= 32'h00000000;
			err_mask_reg <= 32'h00000000;
			deviation_counter_reg <= {DW{1'b0}};
			abort_flag_reg <= 5'h00;
			encoder_input_fault_reg <= 1'b0;
			met_reg <= 5'h00;
			stop_immediate <= 1'b0;
			stop_decel <= 1'b0;
			bulk_override <= 1'b0;
			for (j = 0; j < 5; j = j + 1) begin
				cmp_val_reg[j] <= {CW{1'b0}};
			end
		end else begin
			met_reg <= met_w; // [R23] [R12]
			stop_immediate <= |fire_imm; // [R11]
			stop_decel <= |fire_dec;
			bulk_override <= |fire_bulk;
			deviation_counter_reg <= deviation_counter_next;
			abort_flag_reg <= abort_flag_next;
			// Encoder fault only flags; motion continues.
			if (enc_err) begin
				encoder_input_fault_reg <= 1'b1; // [R13]
			end else if (wr_en && paddr == `CMPLOS_OFS_ERR_CAUSE && pwdata[`CMPLOS_ENCODER_INPUT_FAULT_BIT]) begin
				encoder_input_fault_reg <= 1'b0; // [R22]
			end
			if (wr_en) begin
				case (paddr)
					`CMPLOS_OFS_ENC_CFG: encoder_io_config_reg <= pwdata;
					`CMPLOS_OFS_CMP_CFG_A: comparator_config_a_reg <= pwdata;
					`CMPLOS_OFS_CMP_CFG_B: comparator_config_b_reg <= pwdata;
					default: begin
						if (paddr == ofs_err_mask) begin
							err_mask_reg <= pwdata;
						end
					end
				endcase
				for (j = 0; j < 5; j = j + 1) begin
					if (paddr == `CMPLOS_OFS_CMP_VAL0 + j * 4) begin
						cmp_val_reg[j] <= pwdata[CW-1:0]; // [R19]
					end
				end
			end
		end
	end
	// =====================================================================
	// Read data, registered on the setup cycle so it is stable in access.
	always @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h00000000;
		end else if (rd_en && !penable) begin
			prdata <= 32'h00000000;
			case (paddr)
				`CMPLOS_OFS_ENC_CFG: prdata <= encoder_io_config_reg;
				`CMPLOS_OFS_CMP_CFG_A: prdata <= comparator_config_a_reg;
				`CMPLOS_OFS_CMP_CFG_B: prdata <= comparator_config_b_reg;
				`CMPLOS_OFS_DEV_CNT: prdata <= {{(32-DW){deviation_counter_reg[DW-1]}}, deviation_counter_reg}; // [R17]
				`CMPLOS_OFS_ERR_CAUSE: prdata <= {15'h0000, encoder_input_fault_reg, 11'h000, abort_flag_reg};
				`CMPLOS_OFS_MAIN_STATE: prdata <= {19'h00000, met_reg, 8'h00}; // [R12]
				default: begin
					if (paddr == ofs_err_mask) begin
						prdata <= err_mask_reg;
					end
					for (i = 0; i < 5; i = i + 1) begin
						if (paddr == `CMPLOS_OFS_CMP_VAL0 + i * 4) begin
							prdata <= {{(32-CW){cmp_val_reg[i][CW-1]}}, cmp_val_reg[i]};
						end
					end
				end
			endcase
		end
	end
endmodule
`default_nettype wire

/* testbench/cmplos_enc_model.sv */
// Incremental encoder model that feeds the quadrature phases.
`default_nettype none
module cmplos_enc_model (
	input wire logic clk,
	input wire logic srst,
	input wire logic step_fwd,
	input wire logic both_flip,
	output var logic encoder_phase_a,
	output var logic encoder_phase_b
);
	timeunit 1ns;
	timeprecision 1ns;
	// A forward step flips A when the phases agree, else B, so A always leads.
	always @(posedge clk) begin
		if (srst) begin
			encoder_phase_a <= 1'b0;
			encoder_phase_b <= 1'b0;
		end else if (both_flip) begin
			encoder_phase_a <= ~encoder_phase_a;
			encoder_phase_b <= ~encoder_phase_b;
		end else if (step_fwd) begin
			if (encoder_phase_a == encoder_phase_b) begin
				encoder_phase_a <= ~encoder_phase_a;
			end else begin
				encoder_phase_b <= ~encoder_phase_b;
			end
		end
	end
endmodule
`default_nettype wire

/* testbench/cmplos_props.sv */
// Port checker for the comparator, soft limit and out-of-step block.
`default_nettype none
module cmplos_props (
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic start_pos_req,
	input wire logic start_neg_req,
	input wire logic start_pos_ok,
	input wire logic start_neg_ok,
	input wire logic stop_immediate,
	input wire logic stop_decel,
	input wire logic bulk_override,
	input wire logic [4:0] compare_out,
	input wire logic err_irq
);
	timeunit 1ns;
	timeprecision 1ns;
	// ====================
	// Properties
	// All checks share the one clock, so reset disables them in one place.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (srst);
	// A status read: setup cycle at the main state offset, then access.
	sequence s_rd_acc;
		psel && !penable && !pwrite && paddr == 12'h028 ##1 psel && penable;
	endsequence
	a_pos_refuse:
		assert property (start_pos_req && !start_pos_ok |=> compare_out[0])
		else $error("positive start refused with limit not met");
	a_neg_refuse:
		assert property (start_neg_req && !start_neg_ok |=> compare_out[1])
		else $error("negative start refused with limit not met");
	a_ok_needs_req:
		assert property ((start_pos_req || !start_pos_ok) && (start_neg_req || !start_neg_ok))
		else $error("start granted without a request");
	a_stop_cause:
		assert property (stop_immediate |-> |compare_out)
		else $error("immediate stop without a met comparator");
	a_decel_cause:
		assert property (stop_decel |-> |compare_out)
		else $error("deceleration stop without a met comparator");
	a_bulk_cause:
		assert property (bulk_override |-> |compare_out)
		else $error("bulk override without a met comparator");
	a_irq_sticky:
		assert property ($fell(err_irq) |-> $past(psel && penable && pwrite || srst))
		else $error("error request dropped without a register write");
	a_status_mirror:
		assert property (s_rd_acc |-> prdata[12:8] == $past(compare_out))
		else $error("main state met bits differ from compare outputs");
endmodule
bind cmplos_top cmplos_props u_props (.clk, .srst, .psel, .penable, .pwrite, .paddr, .prdata, .start_pos_req,
	.start_neg_req, .start_pos_ok, .start_neg_ok, .stop_immediate, .stop_decel, .bulk_override, .compare_out, .err_irq);
`default_nettype wire

/* testbench/cmplos_tb_top.sv */
// Self-checking testbench for the comparator and out-of-step block.
`default_nettype none
module cmplos_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, cu = 0, mp = 0, mn = 0, rp = 0, rn = 0, sf = 0, bf = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, rd, v;
	logic [27:0] c1 = 0, c2 = 0, c4 = 0;
	wire [31:0] prdata;
	wire [4:0] co;
	wire pready, pslverr, ea, eb, si, sd, bo, pok, nok, irq;
	int n_errors = 0, check_count = 0, seed = 32'h2a9e, k, a, s, f, n;
	always #50 clk = ~clk;
	cmplos_enc_model u_enc (.clk, .srst, .step_fwd(sf), .both_flip(bf), .encoder_phase_a(ea), .encoder_phase_b(eb));
	cmplos_top DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.position_counter_one(c1), .position_counter_two(c2), .general_counter_four(c4), .speed_step(28'h0),
		.cmd_pulse_up(cu), .cmd_pulse_dn(1'b0), .moving_pos(mp), .moving_neg(mn), .start_pos_req(rp),
		.start_neg_req(rn), .encoder_phase_a(ea), .encoder_phase_b(eb), .stop_immediate(si), .stop_decel(sd),
		.bulk_override(bo), .start_pos_ok(pok), .start_neg_ok(nok), .compare_out(co), .err_irq(irq));
	// ====================
	// Helpers
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One APB transfer; a leading edge keeps it off the previous release.
	task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		pwrite <= wr;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		rd = prdata;
		psel <= 0;
		penable <= 0;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
		apb(1, ad, wd);
	endtask
	task automatic rdchk(input logic [11:0] ad, input logic [31:0] exp);
		apb(0, ad, 0);
		check(rd, exp);
	endtask
	task automatic pulse(input int n, input int which);
		repeat (n) begin
			@(posedge clk);
			if (which == 0) cu <= 1; else if (which == 1) sf <= 1; else bf <= 1;
			@(posedge clk);
			cu <= 0;
			sf <= 0;
			bf <= 0;
		end
		repeat (4) @(posedge clk);
	endtask
	// Comparator k (0-3) aimed at counter two, met when its value is below it; zero for k 4.
	function automatic logic [31:0] cfg_a(input int k, input int a);
		return k == 4 ? 32'h0 : (32'h15 << 8 * k) | (32'(a) << (k == 3 ? 30 : 8 * k + 5));
	endfunction
	task automatic wrap_up;
		if (n_errors == 0 && check_count > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask
	// ====================
	// Scenarios
	initial begin
		repeat (8) @(posedge clk);
		srst <= 0;
		for (k = 0; k < 11; k++) rdchk(12'(4 * k), 0);
		rdchk(12'h040, 0);
		for (k = 0; k < 5; k++) begin
			v = $random(seed);
			wr(12'h010 + 12'(4 * k), v);
			rdchk(12'h010 + 12'(4 * k), {{4{v[27]}}, v[27:0]});
		end
		wr(12'h030, 32'h0001_001f);
		wr(12'h010, 0);
		// Only the selected counter is above zero, so one code cannot pass for another.
		for (k = 0; k < 3; k++) begin
			s = k == 2 ? 3 : k;
			wr(12'h004, 32'h14 | s);
			c1 <= 28'(s == 0 ? 5 : -5);
			c2 <= 28'(s == 1 ? 5 : -5);
			c4 <= 28'(s == 3 ? 5 : -5);
			repeat (2) @(posedge clk);
			check(32'(co), 1);
		end
		c2 <= 7;
		mp <= 1;
		for (k = 0; k < 5; k++)
			for (a = 0; a < 4; a++) begin
				wr(12'h004, 0);
				wr(12'h008, 0);
				wr(12'h024, 32'hffff_ffff);
				wr(12'h010 + 12'(4 * k), 0);
				wr(12'h004, cfg_a(k, a));
				wr(12'h008, k == 4 ? 32'h29 | 32'(a) << 6 : 0);
				repeat (2) @(posedge clk);
				check(32'({si, sd, bo}), 32'(a == 0 ? 0 : 8 >> a));
				check(32'(co), 32'(1) << k);
				check(32'(irq), 32'(a == 1 || a == 2));
				rdchk(12'h028, 32'h100 << k);
				rdchk(12'h024, (a == 1 || a == 2) ? 32'h1 << k : 0);
			end
		// Limits at plus and minus 100; 100 itself must not trip the upper one.
		wr(12'h008, 0);
		wr(12'h014, 32'hffff_ff9c);
		wr(12'h010, 32'd100);
		wr(12'h004, 32'h0000_7818);
		rp <= 1;
		rn <= 1;
		for (k = 0; k < 4; k++) begin
			c1 <= 28'(k == 2 ? -101 : k == 0 ? 100 : 101);
			mp <= k < 2;
			mn <= k >= 2;
			repeat (3) @(posedge clk);
			wr(12'h024, 32'hffff_ffff);
			repeat (2) @(posedge clk);
			n = k == 0 ? 0 : k == 2 ? 2 : 1;
			check(32'(co), n);
			check(32'({nok, pok}), 32'(~n & 3));
			rdchk(12'h024, k == 3 ? 0 : n);
			if (k == 1 || k == 2) check(32'({si, bo}), 2);
		end
		wr(12'h004, 0);
		mp <= 0;
		mn <= 0;
		for (f = 0; f < 3; f++) begin
			n = $random(seed) & 7;
			wr(12'h000, 32'h0040_0000 | f << 20);
			wr(12'h02c, 32'h22);
			rdchk(12'h00c, 0);
			pulse(n, 0);
			pulse(4, 1);
			rdchk(12'h00c, 32'(n - (1 << f)));
		end
		// Deviation of 32 sits on the tolerance; one more step is out of step.
		wr(12'h02c, 32'h22);
		wr(12'h018, 32'd32);
		pulse(32, 1);
		wr(12'h004, 32'h0036_0000);
		mp <= 1;
		repeat (3) @(posedge clk);
		check(32'(co), 0);
		pulse(1, 1);
		check(32'({si, co}), 32'h24);
		rdchk(12'h024, 32'h4);
		wr(12'h004, 0);
		mp <= 0;
		wr(12'h024, 32'hffff_ffff);
		pulse(1, 2);
		check(32'(si), 0);
		rdchk(12'h024, 32'h1_0000);
		pulse(1, 1);
		wr(12'h000, 32'h0070_0000);
		wr(12'h024, 32'hffff_ffff);
		pulse(1, 2);
		rdchk(12'h024, 32'h1_0000);
		wrap_up;
	end
	// Watchdog well beyond the fewer than a thousand cycles the scenarios need.
	initial begin
		repeat (20000) @(posedge clk);
		n_errors++;
		wrap_up;
	end
endmodule
`default_nettype wire
